// File: rtl/dfic_cmd_core.sv
// Purpose: format track, format unit and identify command handling
// Assumes: host writes the task file then pulses CMD_WR_I on the same clock
// Notes: media work is delegated to a media engine via request and done
`timescale 1ns/100ps

// Operation
// - with the addressing bit clear the head nibble is taken as the head number.
// - after a logical track format the current address is returned in the registers.
// - a logical track format covers only the one track holding the given address.
// - code F7h starts the whole-unit format, which moves no data.
// - whole-unit format merges reassignments into defects, clears them, then initialises.
// - new lists take effect at completion, persist, and the old lists are erased.
// - whole-unit format runs from address 0 to the native maximum.
// - whole-unit format aborts unless a security erase prepare came just before.
// - whole-unit format aborts unless the feature register holds 11h.
// - code ECh sends one sector of identify words to the host.
// - identify word 0 reads 045xh with bit 2 showing incomplete data.
// - identify word 2 reads C837h when complete and 37C8h when incomplete.
// - identify word 6 reads 003Fh sectors per track.
module dfic_cmd_core #(
    parameter logic [7:0] SEC_PREP_CODE = 8'hF3
) (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire dfic_pkg::dfic_tf_in_t TASKFILE_I,
    input wire logic CMD_WR_I,
    output dfic_pkg::dfic_tf_out_t TASKFILE_O,
    output logic [15:0] DATA_O,
    output logic DATA_VALID_O,
    input wire logic DATA_READY_I,
    input wire logic IDENT_INCOMPLETE_I,
    input wire logic [15:0] CYLINDERS_I,
    input wire logic [15:0] HEADS_I,
    input wire logic [27:0] NATIVE_MAX_I,
    output logic MEDIA_REQ_O,
    output dfic_pkg::dfic_op_t MEDIA_OP_O,
    output logic MEDIA_LBA_MODE_O,
    output logic [27:0] MEDIA_ADDR_O,
    output logic [27:0] MEDIA_LAST_O,
    output logic [3:0] MEDIA_HEAD_O,
    input wire logic MEDIA_DONE_I,
    input wire logic MEDIA_FAIL_I
);

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    dfic_pkg::dfic_state_t state;
    dfic_pkg::dfic_state_t next_state;
    logic prep_armed;
    logic lba_mode;
    logic [27:0] target;
    logic [7:0] word_idx;
    logic [7:0] next_word_idx;
    logic [15:0] rom_word;
    logic take, is_track, is_unit, is_ident, is_prep, unit_ok, abort_now;
    logic word_step, xfer_end, fail_now, last_step;

    assign take = CMD_WR_I && (state == dfic_pkg::ST_IDLE);
    assign is_track = TASKFILE_I.command == dfic_pkg::CMD_FMT_TRACK;
    assign is_unit = TASKFILE_I.command == dfic_pkg::CMD_FMT_UNIT;
    assign is_ident = TASKFILE_I.command == dfic_pkg::CMD_IDENTIFY;
    assign is_prep = TASKFILE_I.command == SEC_PREP_CODE;
    // unit format needs prepare just before and the merge code
    assign unit_ok = prep_armed && (TASKFILE_I.feature == dfic_pkg::FEAT_MERGE_DEFECTS);
    assign abort_now = take && !(is_track || is_ident || is_prep || (is_unit && unit_ok));
    assign word_step = DATA_VALID_O && DATA_READY_I;
    assign xfer_end = word_step && (word_idx == dfic_pkg::IDENT_LAST_WORD);
    assign fail_now = MEDIA_DONE_I && MEDIA_FAIL_I && MEDIA_REQ_O;
    assign last_step = MEDIA_DONE_I && !MEDIA_FAIL_I
                       && (state == dfic_pkg::ST_TRACK || state == dfic_pkg::ST_COMMIT);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            dfic_pkg::ST_IDLE: begin
                if (take && is_track) begin
                    next_state = dfic_pkg::ST_TRACK;
                end else if (take && is_unit && unit_ok) begin
                    next_state = dfic_pkg::ST_MERGE;
                end else if (take && is_ident) begin
                    next_state = dfic_pkg::ST_IDENT;
                end
            end
            // merge, clear, init, commit in strict order
            dfic_pkg::ST_MERGE: if (MEDIA_DONE_I) next_state = MEDIA_FAIL_I ? dfic_pkg::ST_IDLE
                                                                           : dfic_pkg::ST_CLEAR;
            dfic_pkg::ST_CLEAR: if (MEDIA_DONE_I) next_state = MEDIA_FAIL_I ? dfic_pkg::ST_IDLE
                                                                           : dfic_pkg::ST_INIT;
            dfic_pkg::ST_INIT: if (MEDIA_DONE_I) next_state = MEDIA_FAIL_I ? dfic_pkg::ST_IDLE
                                                                          : dfic_pkg::ST_COMMIT;
            dfic_pkg::ST_TRACK, dfic_pkg::ST_COMMIT: begin
                if (MEDIA_DONE_I) begin
                    next_state = dfic_pkg::ST_IDLE;
                end
            end
            dfic_pkg::ST_IDENT: if (xfer_end) next_state = dfic_pkg::ST_IDLE;
            default: next_state = dfic_pkg::ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state <= dfic_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // prepare must be the command right before the unit format
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            prep_armed <= 1'b0;
        end else if (take) begin
            prep_armed <= is_prep;
        end
    end

    // ----------------------------------------
    // target capture
    // ----------------------------------------
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            lba_mode <= 1'b0;
            target <= 28'h0000000;
        end else if (take && is_track) begin
            lba_mode <= TASKFILE_I.device[dfic_pkg::DEV_LBA_BIT];
            // host placed bits 24-27 in head nibble, 0-23 in low/mid/high
            target <= {TASKFILE_I.device[dfic_pkg::DEV_HEAD_MSB:0], TASKFILE_I.lba_high,
                       TASKFILE_I.lba_mid, TASKFILE_I.lba_low};
        end
    end

    // ----------------------------------------
    // media engine requests
    // ----------------------------------------
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            MEDIA_REQ_O <= 1'b0;
            MEDIA_OP_O <= dfic_pkg::OP_TRACK;
            MEDIA_LBA_MODE_O <= 1'b0;
            MEDIA_ADDR_O <= 28'h0000000;
            MEDIA_LAST_O <= 28'h0000000;
            MEDIA_HEAD_O <= 4'h0;
        end else begin
            MEDIA_REQ_O <= 1'b0;
            MEDIA_LAST_O <= 28'h0000000;
            case (next_state)
                dfic_pkg::ST_TRACK: begin
                    MEDIA_REQ_O <= 1'b1;
                    MEDIA_OP_O <= dfic_pkg::OP_TRACK;
                    if (take) begin
                        MEDIA_LBA_MODE_O <= TASKFILE_I.device[dfic_pkg::DEV_LBA_BIT];
                        // head nibble is the head number in cylinder mode
                        MEDIA_HEAD_O <= TASKFILE_I.device[dfic_pkg::DEV_HEAD_MSB:0];
                        // one track: the one holding this address, or this cylinder
                        MEDIA_ADDR_O <= TASKFILE_I.device[dfic_pkg::DEV_LBA_BIT]
                            ? {TASKFILE_I.device[dfic_pkg::DEV_HEAD_MSB:0], TASKFILE_I.lba_high,
                               TASKFILE_I.lba_mid, TASKFILE_I.lba_low}
                            : {12'h000, TASKFILE_I.lba_high, TASKFILE_I.lba_mid};
                    end
                end
                dfic_pkg::ST_MERGE: begin
                    MEDIA_REQ_O <= 1'b1;
                    MEDIA_OP_O <= dfic_pkg::OP_MERGE;
                end
                dfic_pkg::ST_CLEAR: begin
                    MEDIA_REQ_O <= 1'b1;
                    MEDIA_OP_O <= dfic_pkg::OP_CLEAR;
                end
                dfic_pkg::ST_INIT: begin
                    MEDIA_REQ_O <= 1'b1;
                    MEDIA_OP_O <= dfic_pkg::OP_INIT;
                    MEDIA_LBA_MODE_O <= 1'b1;
                    // whole native range, host limit not consulted
                    MEDIA_ADDR_O <= 28'h0000000;
                    MEDIA_LAST_O <= NATIVE_MAX_I;
                end
                dfic_pkg::ST_COMMIT: begin
                    MEDIA_REQ_O <= 1'b1;
                    MEDIA_OP_O <= dfic_pkg::OP_COMMIT;
                end
                default: MEDIA_REQ_O <= 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // identify transfer
    // ----------------------------------------
    assign next_word_idx = (take && is_ident) ? 8'h00
                         : (word_step ? word_idx + 8'h01 : word_idx);

    dfic_ident_rom u_rom (
        .word_idx(next_word_idx),
        .incomplete(IDENT_INCOMPLETE_I),
        .cylinders(CYLINDERS_I),
        .heads(HEADS_I),
        .word(rom_word)
    );

    // one word per accepted handshake, 256 words
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            word_idx <= 8'h00;
            DATA_O <= 16'h0000;
            DATA_VALID_O <= 1'b0;
        end else begin
            word_idx <= next_word_idx;
            DATA_O <= rom_word;
            DATA_VALID_O <= (next_state == dfic_pkg::ST_IDENT);
        end
    end

    // ----------------------------------------
    // task-file readback
    // ----------------------------------------
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            TASKFILE_O <= '{status: dfic_pkg::STATUS_IDLE, error: dfic_pkg::ERROR_NONE,
                            default: 8'h00};
        end else begin
            if (take) begin
                TASKFILE_O.lba_low <= TASKFILE_I.lba_low;
                TASKFILE_O.lba_mid <= TASKFILE_I.lba_mid;
                TASKFILE_O.lba_high <= TASKFILE_I.lba_high;
                TASKFILE_O.device <= TASKFILE_I.device;
                if (abort_now) begin
                    TASKFILE_O.error <= dfic_pkg::ERROR_ABORT;
                    TASKFILE_O.status <= dfic_pkg::STATUS_FAIL;
                end else begin
                    TASKFILE_O.error <= dfic_pkg::ERROR_NONE;
                    TASKFILE_O.status <= is_prep ? dfic_pkg::STATUS_IDLE
                                       : (is_ident ? dfic_pkg::STATUS_XFER
                                                   : dfic_pkg::STATUS_BUSY);
                end
            end else if (fail_now) begin
                TASKFILE_O.error <= dfic_pkg::ERROR_NOT_FOUND;
                TASKFILE_O.status <= dfic_pkg::STATUS_FAIL;
            end else if (last_step || xfer_end) begin
                TASKFILE_O.status <= dfic_pkg::STATUS_IDLE;
                if (state == dfic_pkg::ST_TRACK && lba_mode) begin
                    // current address back in low/mid/high and head nibble
                    TASKFILE_O.lba_low <= target[7:0];
                    TASKFILE_O.lba_mid <= target[15:8];
                    TASKFILE_O.lba_high <= target[23:16];
                    TASKFILE_O.device[dfic_pkg::DEV_HEAD_MSB:0] <= target[27:24];
                end
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);

    unknown_cmd_abort_a: assert property (take && !is_track && !is_unit && !is_ident && !is_prep
        |=> TASKFILE_O.error[dfic_pkg::ERR_ABT] && TASKFILE_O.status[dfic_pkg::STAT_ERR]
            && !TASKFILE_O.status[dfic_pkg::STAT_BSY] && state == dfic_pkg::ST_IDLE)
        else $error("unknown command not aborted");
    unit_feature_a: assert property (take && is_unit
        && TASKFILE_I.feature != dfic_pkg::FEAT_MERGE_DEFECTS
        |=> TASKFILE_O.error == dfic_pkg::ERROR_ABORT && !MEDIA_REQ_O)
        else $error("unit format ran with wrong feature");
    unit_prep_a: assert property (take && is_unit && !prep_armed
        |=> TASKFILE_O.status == dfic_pkg::STATUS_FAIL && state == dfic_pkg::ST_IDLE)
        else $error("unit format ran without prepare");
    unit_start_a: assert property (take && is_unit && unit_ok
        |=> MEDIA_REQ_O && MEDIA_OP_O == dfic_pkg::OP_MERGE)
        else $error("unit format did not start merge");
    unit_order_a: assert property (state == dfic_pkg::ST_CLEAR && MEDIA_DONE_I && !MEDIA_FAIL_I
        |=> MEDIA_OP_O == dfic_pkg::OP_INIT ##0 MEDIA_ADDR_O == 28'h0000000
            ##0 MEDIA_LAST_O == $past(NATIVE_MAX_I))
        else $error("init step wrong order or range");
    chs_head_a: assert property (take && is_track && !TASKFILE_I.device[dfic_pkg::DEV_LBA_BIT]
        |=> MEDIA_REQ_O && !MEDIA_LBA_MODE_O
            && MEDIA_HEAD_O == $past(TASKFILE_I.device[3:0]))
        else $error("track head number not taken");
    lba_return_a: assert property (state == dfic_pkg::ST_TRACK && lba_mode && last_step
        |=> {TASKFILE_O.device[3:0], TASKFILE_O.lba_high, TASKFILE_O.lba_mid,
             TASKFILE_O.lba_low} == target && TASKFILE_O.status == dfic_pkg::STATUS_IDLE)
        else $error("current address not returned");
    ident_word0_a: assert property (DATA_VALID_O && word_idx == 8'h00 && $past(take)
        |-> DATA_O == (dfic_pkg::IDENT_W0_BASE | {13'h0000, $past(IDENT_INCOMPLETE_I), 2'b00}))
        else $error("identify word 0 wrong");
    ident_word2_a: assert property (DATA_VALID_O && word_idx == 8'h02
        |-> DATA_O == ($past(IDENT_INCOMPLETE_I) ? 16'h37C8 : 16'hC837))
        else $error("identify word 2 wrong");
    ident_word6_a: assert property (DATA_VALID_O && word_idx == 8'h06
        |-> DATA_O == 16'h003F)
        else $error("identify word 6 wrong");

    track_lba_c: cover property (state == dfic_pkg::ST_TRACK && lba_mode && last_step);
    unit_done_c: cover property (state == dfic_pkg::ST_COMMIT && last_step);
    ident_done_c: cover property (xfer_end);
    unit_abort_c: cover property (take && is_unit && !unit_ok);

endmodule

// File: rtl/dfic_ident_rom.sv
// Purpose: identify sector word lookup
// Assumes: index is the word number within the sector
// Notes: words past the covered ones read as zero
`timescale 1ns/100ps
module dfic_ident_rom (
    input wire logic [7:0] word_idx,
    input wire logic incomplete,
    input wire logic [15:0] cylinders,
    input wire logic [15:0] heads,
    output logic [15:0] word
);

    // ----------------------------------------
    // word table
    // ----------------------------------------
    always_comb begin
        case (word_idx)
            8'h00: begin
                word = dfic_pkg::IDENT_W0_BASE;
                word[dfic_pkg::IDENT_W0_INCOMPLETE] = incomplete;
            end
            8'h01: word = cylinders;
            8'h02: word = incomplete ? dfic_pkg::IDENT_W2_INCOMPLETE
                                     : dfic_pkg::IDENT_W2_COMPLETE;
            8'h03: word = heads;
            8'h06: word = dfic_pkg::IDENT_W6_SECTORS;
            default: word = 16'h0000;
        endcase
    end

endmodule

// File: rtl/dfic_pkg.sv
// Purpose: constants and carriers for the format and identify command block
// Assumes: host task-file logic runs on the same clock as the device
// Notes: status and error bytes are built from named bit positions
package dfic_pkg;

    // ----------------------------------------
    // command codes and feature codes
    // ----------------------------------------
    localparam logic [7:0] CMD_FMT_TRACK = 8'h50;
    localparam logic [7:0] CMD_FMT_UNIT = 8'hF7;
    localparam logic [7:0] CMD_IDENTIFY = 8'hEC;
    localparam logic [7:0] FEAT_MERGE_DEFECTS = 8'h11;

    // ----------------------------------------
    // device register fields
    // ----------------------------------------
    localparam int DEV_LBA_BIT = 6;
    localparam int DEV_HEAD_MSB = 3;

    // ----------------------------------------
    // status and error bit positions
    // ----------------------------------------
    localparam int STAT_BSY = 7;
    localparam int STAT_RDY = 6;
    localparam int STAT_DSC = 4;
    localparam int STAT_DRQ = 3;
    localparam int STAT_ERR = 0;
    localparam int ERR_IDN = 4;
    localparam int ERR_ABT = 2;

    // ----------------------------------------
    // status and error byte values
    // ----------------------------------------
    localparam logic [7:0] STATUS_IDLE = (8'h01 << STAT_RDY) | (8'h01 << STAT_DSC);
    localparam logic [7:0] STATUS_BUSY = STATUS_IDLE | (8'h01 << STAT_BSY);
    localparam logic [7:0] STATUS_XFER = STATUS_IDLE | (8'h01 << STAT_DRQ);
    localparam logic [7:0] STATUS_FAIL = STATUS_IDLE | (8'h01 << STAT_ERR);
    localparam logic [7:0] ERROR_NONE = 8'h00;
    localparam logic [7:0] ERROR_ABORT = 8'h01 << ERR_ABT;
    localparam logic [7:0] ERROR_NOT_FOUND = 8'h01 << ERR_IDN;

    // ----------------------------------------
    // identify sector layout
    // ----------------------------------------
    localparam logic [7:0] IDENT_LAST_WORD = 8'hFF;
    localparam logic [15:0] IDENT_W0_BASE = 16'h045A;
    localparam int IDENT_W0_INCOMPLETE = 2;
    localparam logic [15:0] IDENT_W2_COMPLETE = 16'hC837;
    localparam logic [15:0] IDENT_W2_INCOMPLETE = 16'h37C8;
    localparam logic [15:0] IDENT_W6_SECTORS = 16'h003F;

    // ----------------------------------------
    // carriers, states and media operations
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] command;
        logic [7:0] feature;
        logic [7:0] count;
        logic [7:0] lba_low;
        logic [7:0] lba_mid;
        logic [7:0] lba_high;
        logic [7:0] device;
    } dfic_tf_in_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] error;
        logic [7:0] lba_low;
        logic [7:0] lba_mid;
        logic [7:0] lba_high;
        logic [7:0] device;
    } dfic_tf_out_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TRACK = 3'b001,
        ST_MERGE = 3'b010,
        ST_CLEAR = 3'b011,
        ST_INIT = 3'b100,
        ST_COMMIT = 3'b101,
        ST_IDENT = 3'b110
    } dfic_state_t;

    typedef enum logic [2:0] {
        OP_TRACK = 3'b000,
        OP_MERGE = 3'b001,
        OP_CLEAR = 3'b010,
        OP_INIT = 3'b011,
        OP_COMMIT = 3'b100
    } dfic_op_t;

endpackage

// File: verification/dfic_media_model.sv
// Purpose: media engine stand-in that answers step requests
// Assumes: one step at a time, request held until its done
// Notes: done pulses four cycles into a step, fail rides on done
`timescale 1ns/100ps
module dfic_media_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic fail_en_i,
    output logic done_o,
    output logic fail_o
);
    // ----------------------------------------
    // step timing
    // ----------------------------------------
    logic [3:0] wait_cnt;
    // count held request, pulse done, restart on next step
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt <= 4'h0;
            done_o <= 1'h0;
        end else if (done_o || !req_i) begin
            wait_cnt <= 4'h0;
            done_o <= 1'h0;
        end else if (wait_cnt == 4'h3) begin
            done_o <= 1'h1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    assign fail_o = done_o & fail_en_i; // failure only with done
endmodule

// File: verification/testbench.sv
// Purpose: self-checking bench for the format and identify commands
// Assumes: inputs driven at the falling edge, outputs read there
// Notes: media steps answered by the media model
`timescale 1ns/100ps
module testbench;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam logic [7:0] PREP = 8'hF3;
    localparam logic [27:0] NATIVE = 28'h9ABCDEF;
    logic clk, rst, cmd_wr, valid, ready, incomplete, req, lba_mode, done, fail, fail_en;
    logic [15:0] data;
    logic [27:0] addr, last;
    logic [3:0] head;
    dfic_pkg::dfic_op_t op;
    dfic_pkg::dfic_tf_in_t tf_in;
    dfic_pkg::dfic_tf_out_t tf_out;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    dfic_cmd_core #(.SEC_PREP_CODE(PREP)) DUT (.CLOCK_I(clk), .SYS_RST_I(rst),
        .TASKFILE_I(tf_in), .CMD_WR_I(cmd_wr), .TASKFILE_O(tf_out), .DATA_O(data),
        .DATA_VALID_O(valid), .DATA_READY_I(ready), .IDENT_INCOMPLETE_I(incomplete),
        .CYLINDERS_I(16'h1234), .HEADS_I(16'h0010), .NATIVE_MAX_I(NATIVE),
        .MEDIA_REQ_O(req), .MEDIA_OP_O(op), .MEDIA_LBA_MODE_O(lba_mode),
        .MEDIA_ADDR_O(addr), .MEDIA_LAST_O(last), .MEDIA_HEAD_O(head),
        .MEDIA_DONE_I(done), .MEDIA_FAIL_I(fail));
    dfic_media_model media (.clk_i(clk), .rst_i(rst), .req_i(req), .fail_en_i(fail_en),
        .done_o(done), .fail_o(fail));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic issue(input logic [7:0] cmd, feat, dev, input logic [23:0] a);
        tf_in = '0;
        tf_in.command = cmd;
        tf_in.feature = feat;
        tf_in.device = dev;
        {tf_in.lba_high, tf_in.lba_mid, tf_in.lba_low} = a;
        cmd_wr = 1'h1;
        @(negedge clk);
        cmd_wr = 1'h0;
    endtask
    task automatic prep_unit(input logic [7:0] feat);
        issue(PREP, 8'h00, 8'h00, 24'h0);
        chk(tf_out.status, 8'h50);
        @(negedge clk);
        issue(dfic_pkg::CMD_FMT_UNIT, feat, 8'h00, 24'h0);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        // host-side step timeout, 50 cycles, far above the four cycles a media step takes
        while (done !== 1'h1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk(done, 1'h1);
        @(negedge clk);
    endtask
    function automatic logic [15:0] ident_exp(input int i, input logic inc);
        case (i)
            0: ident_exp = 16'h045A | (16'(inc) << 2);
            1: ident_exp = 16'h1234;
            2: ident_exp = inc ? 16'h37C8 : 16'hC837;
            3: ident_exp = 16'h0010;
            6: ident_exp = 16'h003F;
            default: ident_exp = 16'h0000;
        endcase
    endfunction
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock, timeout and test sequence
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            report_and_stop;
        end
    end
    // scenarios in order
    initial begin
        rst = 1'h1;
        tf_in = '0;
        {cmd_wr, ready, incomplete, fail_en} = 4'h0;
        repeat (12) @(negedge clk);
        rst = 1'h0;
        @(negedge clk);
        chk(tf_out.status, 8'h50);
        chk(tf_out.error, 8'h00);
        // logical track format returns the address
        issue(dfic_pkg::CMD_FMT_TRACK, 8'h00, 8'h4A, 24'h563412);
        chk(tf_out.status, 8'hD0);
        chk(lba_mode, 1'h1);
        chk(addr, 28'hA563412);
        wait_done;
        chk(tf_out.status, 8'h50);
        chk({tf_out.device[3:0], tf_out.lba_high, tf_out.lba_mid, tf_out.lba_low},
            28'hA563412);
        // cylinder and head track format
        issue(dfic_pkg::CMD_FMT_TRACK, 8'h00, 8'h05, 24'h563412);
        chk(lba_mode, 1'h0);
        chk(head, 4'h5);
        chk(addr, 28'h0005634);
        wait_done;
        // unit format without prepare, then with a bad feature
        issue(dfic_pkg::CMD_FMT_UNIT, 8'h11, 8'h00, 24'h0);
        chk(tf_out.status, 8'h51);
        chk(tf_out.error, 8'h04);
        chk(req, 1'h0);
        @(negedge clk);
        prep_unit(8'h10);
        chk(tf_out.status, 8'h51);
        chk(tf_out.error, 8'h04);
        @(negedge clk);
        // full unit format: merge, clear, init, commit
        prep_unit(8'h11);
        for (int k = 1; k < 5; k++) begin
            chk(req, 1'h1);
            chk(op, k);
            if (k == 3) begin
                chk(addr, 28'h0);
                chk(last, NATIVE);
            end
            chk(valid, 1'h0);
            wait_done;
        end
        chk(req, 1'h0);
        chk(tf_out.status, 8'h50);
        // media failure on the first step (merge) of the unit format
        fail_en = 1'h1;
        prep_unit(8'h11);
        wait_done;
        fail_en = 1'h0;
        chk(tf_out.status, 8'h51);
        chk(tf_out.error, 8'h10);
        chk(req, 1'h0);
        // identify, complete then incomplete, with an early stall
        for (int inc_i = 0; inc_i < 2; inc_i++) begin
            incomplete = inc_i[0];
            issue(dfic_pkg::CMD_IDENTIFY, 8'h00, 8'h00, 24'h0);
            chk(tf_out.status, 8'h58);
            @(negedge clk);
            chk(data, ident_exp(0, inc_i[0]));
            ready = 1'h1;
            for (int i = 0; i < 256; i++) begin
                chk(valid, 1'h1);
                if (i < 10) chk(data, ident_exp(i, inc_i[0]));
                @(negedge clk);
            end
            ready = 1'h0;
            chk(valid, 1'h0);
            chk(tf_out.status, 8'h50);
            @(negedge clk);
        end
        report_and_stop;
    end
endmodule
